// [bench/testbench.sv]
`timescale 1ns/1ps
`include "tod_cfg.svh"
module testbench import tod_pkg::*;;
    logic        pclk, presetn, ce, psel, penable, pwrite, sample_vld, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] sample_signal, sample_reference;
    logic        det_change, prox_out, touch_out, main_out, main_out_en, aux_out;
    logic        ctrl_is_output, ctrl_freeze_mode, stream_en, cal_delay_sel;
    logic [9:0]  gain_target;
    tod_det_t    det_state;
    tod_power_t  power_mode;
    tod_freeze_t freeze_sel;
    int          errors, checked;
    localparam int REF = 2000;
    localparam logic [9:0] GT [8] = '{10'h0c8, 10'h0fa, 10'h12c, 10'h15e, 10'h190, 10'h226, 10'h2bc, 10'h352};
    localparam logic [9:0] TT [8] = '{10'h028, 10'h03c, 10'h064, 10'h0c8, 10'h168, 10'h1f4, 10'h384, 10'h384};

    tod_top tod_top_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sample_vld, .sample_signal, .sample_reference, .det_state, .det_change, .prox_out,
        .touch_out, .main_out, .main_out_en, .aux_out, .ctrl_is_output, .ctrl_freeze_mode, .stream_en,
        .power_mode, .freeze_sel, .cal_delay_sel, .gain_target);

    initial begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end
    // ----------------------------------------------------------------
    // bus and compare helpers
    // ----------------------------------------------------------------
    task chk(input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1) begin
            errors++;
            stop_test;
        end
    endtask
    // gaps between bursts carry no sample, so a run is not broken by them
    task burst(input int sig, input int n);
        repeat (n) begin
            @(posedge pclk);
            sample_vld <= 1;
            sample_signal <= 16'(sig);
        end
        @(posedge pclk);
        sample_vld <= 0;
        repeat (3) @(posedge pclk);
    endtask
    task rst;
        presetn <= 0;
        repeat (8) @(posedge pclk);
        presetn <= 1;
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] thr, md, an;
        int         tl, pl, rl, n, m;
        logic       pol;
        {presetn, psel, penable, pwrite, sample_vld, paddr, pwdata} = '0;
        ce = 1;
        sample_signal = 16'(REF);
        sample_reference = 16'(REF);
        void'($urandom(32'hc86048fb));
        rst;
        apb(0, `TOD_OFF_THR, 0);
        chk(q, 0);
        apb(0, `TOD_OFF_MODE, 0);
        chk(q, 0);
        chk(gain_target, 10'h0c8);
        chk(prox_out, 1);
        apb(1, `TOD_OFF_ANA, 32'hff);
        apb(0, `TOD_OFF_ANA, 0);
        chk(q, 32'h3e);
        apb(0, 8'h1c, 0);
        chk(e, 1);
        $display("test defaults done");
        for (int it = 0; it < 6; it++) begin
            rst;
            thr = 8'($urandom) & `TOD_THR_WMASK;
            md = 8'($urandom) & `TOD_MODE_WMASK;
            an = 8'($urandom) & `TOD_ANA_WMASK;
            n = 2 + $urandom % 3;
            m = 1 + $urandom % 4;
            apb(1, `TOD_OFF_THR, thr);
            apb(1, `TOD_OFF_MODE, md);
            apb(1, `TOD_OFF_ANA, an);
            apb(1, `TOD_OFF_DBC, {m[7:0], n[7:0]});
            apb(1, `TOD_OFF_CTRL, 1);
            repeat (4) @(posedge pclk);
            apb(1, `TOD_OFF_THR, ~thr);
            apb(0, `TOD_OFF_THR, 0);
            chk(q, thr);
            chk(gain_target, GT[an[3:1]]);
            chk(stream_en, md[7]);
            chk(32'(power_mode), md[6:5]);
            chk(32'(freeze_sel), md[4:3]);
            chk(ctrl_is_output, md[0]);
            chk(ctrl_freeze_mode, thr[0]);
            chk(cal_delay_sel, md[2]);
            tl = TT[thr[7:5]];
            pl = 4 << thr[4:3];
            rl = an[4] ? tl * 9 / 10 : tl * 3 / 4;
            pol = thr[1];
            apb(0, `TOD_OFF_LVL, 0);
            chk(q, {6'h0, 10'(rl), 6'(pl), 10'(tl)});
            burst(REF - tl - 1, n - 1);
            burst(REF, 1);
            burst(REF - tl - 1, n - 1);
            chk(det_state, TOD_IDLE);
            burst(REF - tl - 1, 1);
            chk(det_state, TOD_TOUCH);
            chk(touch_out, pol);
            burst(REF + rl + 1, m - 1);
            chk(det_state, TOD_TOUCH);
            burst(REF + rl + 1, 1);
            chk(det_state, TOD_IDLE);
            chk(touch_out, !pol);
            burst(REF - pl - 1, n);
            chk(det_state, TOD_PROX);
            chk(main_out, (an[5] | md[0]) ? !pol : pol);
            chk(prox_out, pol);
            chk(aux_out, md[0] & pol);
            chk(main_out_en, !md[7]);
            // with the clock enable low, release samples must not end the detection
            ce <= 0;
            burst(REF, 4);
            chk(det_state, TOD_PROX);
            ce <= 1;
            $display("test options %0d done", it);
        end
        stop_test;
    end
endmodule
bind tod_top tod_top_props tod_top_props_i (.pclk, .presetn, .psel, .pwrite, .paddr, .sample_vld, .det_state,
    .det_change, .prox_out, .touch_out, .main_out, .main_out_en, .aux_out, .ctrl_is_output, .stream_en,
    .gain_target);

// [bench/tod_top_props.sv]
`timescale 1ns/1ps
module tod_top_props import tod_pkg::*; (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       pwrite,
    input wire logic [7:0] paddr,
    input wire logic       sample_vld,
    input wire tod_det_t   det_state,
    input wire logic       det_change,
    input wire logic       prox_out,
    input wire logic       touch_out,
    input wire logic       main_out,
    input wire logic       main_out_en,
    input wire logic       aux_out,
    input wire logic       ctrl_is_output,
    input wire logic       stream_en,
    input wire logic [9:0] gain_target
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles since the last lock write; saturates so it never wraps
    logic [3:0] since_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) since_ff <= 4'hf;
        else if (psel && pwrite && paddr == 8'h0c) since_ff <= 4'h0;
        else if (since_ff != 4'hf) since_ff <= since_ff + 4'h1;
    end
    chg_pulse_a: assert property (det_change == $changed(det_state))
        else $error("change pulse does not match state change");
    sample_cause_a: assert property ($changed(det_state) |-> $past(sample_vld))
        else $error("state changed without a sample");
    touch_exit_a: assert property ($past(det_state) == TOD_TOUCH |-> det_state != TOD_PROX)
        else $error("touch left for proximity");
    pin_pair_a: assert property ((touch_out != prox_out) == ($past(det_state) == TOD_PROX))
        else $error("touch and proximity pins disagree with state");
    dual_main_a: assert property (ctrl_is_output && $past(ctrl_is_output, 2) |-> main_out == touch_out)
        else $error("dual mode main output not touch");
    aux_ctrl_a: assert property (!ctrl_is_output && !$past(ctrl_is_output, 2) |-> !aux_out)
        else $error("aux output active in control mode");
    stream_oe_a: assert property (stream_en && $past(stream_en) |-> !main_out_en)
        else $error("main output driven while streaming");
    gain_legal_a: assert property (gain_target inside {10'h0c8, 10'h0fa, 10'h12c, 10'h15e,
        10'h190, 10'h226, 10'h2bc, 10'h352}) else $error("gain target off table");
    opt_hold_a: assert property ($changed(gain_target) |-> since_ff < 4'h6)
        else $error("option decode changed without lock");
    cover property (det_state == TOD_TOUCH);
    cover property (det_state == TOD_PROX);
    cover property (stream_en && ctrl_is_output);
endmodule

// [verilog/tod_cfg.svh]
`ifndef TOD_CFG_SVH
`define TOD_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define TOD_OFF_THR        8'h00
`define TOD_OFF_MODE       8'h04
`define TOD_OFF_ANA        8'h08
`define TOD_OFF_CTRL       8'h0c
`define TOD_OFF_DBC        8'h10
`define TOD_OFF_STAT       8'h14
`define TOD_OFF_LVL        8'h18

// ----------------------------------------------------------------
// reset values and writable-bit masks (reserved bits held at zero)
// ----------------------------------------------------------------
`define TOD_OPT_RST        8'h00
`define TOD_ANA_WMASK      8'h3e
`define TOD_MODE_WMASK     8'hfd
`define TOD_THR_WMASK      8'hfb

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TOD_ANA_TYPE       5
`define TOD_ANA_RATIO      4
`define TOD_ANA_GAIN_LO    1
`define TOD_MODE_STREAM    7
`define TOD_MODE_PWR_LO    5
`define TOD_MODE_FRZ_LO    3
`define TOD_MODE_DYC       2
`define TOD_MODE_DUAL      0
`define TOD_THR_TOUCH_LO   5
`define TOD_THR_PROX_LO    3
`define TOD_THR_POL        1
`define TOD_THR_CTYPE      0
`define TOD_CTRL_LOAD      0
`define TOD_DBC_EXIT_LO    8

// ----------------------------------------------------------------
// level tables
// ----------------------------------------------------------------
`define TOD_TOUCH_0        10'h028
`define TOD_TOUCH_1        10'h03c
`define TOD_TOUCH_2        10'h064
`define TOD_TOUCH_3        10'h0c8
`define TOD_TOUCH_4        10'h168
`define TOD_TOUCH_5        10'h1f4
`define TOD_TOUCH_7        10'h384
`define TOD_PROX_0         6'h04
`define TOD_PROX_1         6'h08
`define TOD_PROX_2         6'h10
`define TOD_PROX_3         6'h20
`define TOD_GAIN_0         10'h0c8
`define TOD_GAIN_1         10'h0fa
`define TOD_GAIN_2         10'h12c
`define TOD_GAIN_3         10'h15e
`define TOD_GAIN_4         10'h190
`define TOD_GAIN_5         10'h226
`define TOD_GAIN_6         10'h2bc
`define TOD_GAIN_7         10'h352
`define TOD_REL_LO_NUM     14'h0003
`define TOD_REL_LO_DEN     14'h0004
`define TOD_REL_HI_NUM     14'h0009
`define TOD_REL_HI_DEN     14'h000a

`endif

// [verilog/tod_debounce.sv]
`timescale 1ns/1ps
module tod_debounce import tod_pkg::*; #(
    parameter int CW = 4
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           ce,
    input  wire logic           sample_vld,
    input  wire tod_det_t       cur_state,
    input  wire tod_det_t       cand_state,
    input  wire logic [CW-1:0]  required,
    output logic [CW-1:0]       run_count,
    output logic                fire
);
    logic [CW-1:0] run_ff;
    tod_det_t      last_ff;

    wire differs   = (cand_state != cur_state);
    wire same_cand = (cand_state == last_ff);
    wire [CW-1:0] nxt_run = (differs && same_cand && run_ff != '0) ? run_ff + 1'b1 : {{(CW-1){1'b0}}, differs};

    // a sample back on the original side, or a different crossing, restarts the run
    assign fire      = sample_vld && differs && (nxt_run >= required);
    assign run_count = run_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff  <= '0;
            last_ff <= TOD_IDLE;
        end else if (ce && sample_vld) begin
            run_ff  <= fire ? '0 : nxt_run;
            last_ff <= cand_state;
        end
    end
endmodule

// [verilog/tod_pkg.sv]
package tod_pkg;

    typedef enum logic [1:0] {
        TOD_IDLE,
        TOD_PROX,
        TOD_TOUCH
    } tod_det_t;

    typedef enum logic [1:0] {
        TOD_FRZ_INFINITE,
        TOD_FRZ_TIMEOUT2,
        TOD_FRZ_TIMEOUT3,
        TOD_FRZ_TIMEOUT1
    } tod_freeze_t;

    typedef enum logic [1:0] {
        TOD_PWR_NORMAL,
        TOD_PWR_LOW1,
        TOD_PWR_LOW2,
        TOD_PWR_LOW3
    } tod_power_t;

endpackage

// [verilog/tod_top.sv]
`timescale 1ns/1ps
`include "tod_cfg.svh"

// Function
// - report a detection change only after consecutive samples stay past the threshold
// - separate consecutive-sample counts for entering and for ending a detection
// - unprogrammed option bytes read zero and select the zero encodings
// - analog byte bit five picks proximity or touch on the main output; dual mode forces touch
// - analog byte bit four picks release at 75 or 90 percent of touch
// - gain code 000..111 gives 200,250,300,350,400,550,700,850
// - mode byte bit seven disables or enables data streaming
// - power field picks normal or low power levels one to three
// - freeze field picks infinite, timeout two, timeout three, timeout one
// - mode byte bit zero makes the shared pin control input or proximity output
// - touch code maps to 40,60,100,200,360,500,undefined,900
// - proximity code maps to 4,8,16,32
// - threshold byte bit one makes detection outputs active low or high
// - threshold byte bit zero picks halt-conversion or reference-freeze control
// - idle to proximity when reference minus signal exceeds proximity level
// - idle or proximity to touch when reference minus signal exceeds touch level
// - touch to idle when signal minus reference exceeds release level
// - release level is touch level times the selected ratio
module tod_top import tod_pkg::*; #(
    parameter int SW        = 16,
    parameter int CW        = 4,
    parameter int ENTRY_DEF = 3,
    parameter int EXIT_DEF  = 3
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           ce,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic           sample_vld,
    input  wire logic [SW-1:0]  sample_signal,
    input  wire logic [SW-1:0]  sample_reference,
    output tod_det_t            det_state,
    output logic                det_change,
    output logic                prox_out,
    output logic                touch_out,
    output logic                main_out,
    output logic                main_out_en,
    output logic                aux_out,
    output logic                ctrl_is_output,
    output logic                ctrl_freeze_mode,
    output logic                stream_en,
    output tod_power_t          power_mode,
    output tod_freeze_t         freeze_sel,
    output logic                cal_delay_sel,
    output logic [9:0]          gain_target
);

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    if (SW < 11 || SW > 24) begin : g_bad_sw
        $error("tod_top: SW must lie in 11..24");
    end
    if (CW < 1 || CW > 8 || ENTRY_DEF < 1 || EXIT_DEF < 1 ||
        ENTRY_DEF >= (1 << CW) || EXIT_DEF >= (1 << CW)) begin : g_bad_cw
        $error("tod_top: debounce counts do not fit CW or are zero");
    end

    // ----------------------------------------------------------------
    // decode functions
    // ----------------------------------------------------------------
    function automatic logic [9:0] touch_of(input logic [2:0] code);
        unique case (code)
            3'h0:    touch_of = `TOD_TOUCH_0;
            3'h1:    touch_of = `TOD_TOUCH_1;
            3'h2:    touch_of = `TOD_TOUCH_2;
            3'h3:    touch_of = `TOD_TOUCH_3;
            3'h4:    touch_of = `TOD_TOUCH_4;
            3'h5:    touch_of = `TOD_TOUCH_5;
            // undefined code: treated as the highest, least sensitive level
            default: touch_of = `TOD_TOUCH_7;
        endcase
    endfunction

    function automatic logic [5:0] prox_of(input logic [1:0] code);
        unique case (code)
            2'h0: prox_of = `TOD_PROX_0;
            2'h1: prox_of = `TOD_PROX_1;
            2'h2: prox_of = `TOD_PROX_2;
            2'h3: prox_of = `TOD_PROX_3;
        endcase
    endfunction

    function automatic logic [9:0] gain_of(input logic [2:0] code);
        unique case (code)
            3'h0: gain_of = `TOD_GAIN_0;
            3'h1: gain_of = `TOD_GAIN_1;
            3'h2: gain_of = `TOD_GAIN_2;
            3'h3: gain_of = `TOD_GAIN_3;
            3'h4: gain_of = `TOD_GAIN_4;
            3'h5: gain_of = `TOD_GAIN_5;
            3'h6: gain_of = `TOD_GAIN_6;
            3'h7: gain_of = `TOD_GAIN_7;
        endcase
    endfunction

    // division by a constant; only evaluated on the latched byte, so its depth is harmless
    function automatic logic [9:0] release_of(input logic [9:0] tl, input logic hi);
        logic [13:0] prod;
        prod = hi ? {4'h0, tl} * `TOD_REL_HI_NUM : {4'h0, tl} * `TOD_REL_LO_NUM;
        prod = hi ? prod / `TOD_REL_HI_DEN : prod / `TOD_REL_LO_DEN;
        release_of = prod[9:0];
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]    thr_opt_ff, mode_opt_ff, ana_opt_ff;
    logic [7:0]    thr_lk_ff, mode_lk_ff, ana_lk_ff;
    logic          locked_ff;
    logic [CW-1:0] entry_cnt_ff, exit_cnt_ff;
    logic [9:0]    touch_lvl_ff, release_lvl_ff;
    logic [5:0]    prox_lvl_ff;
    tod_det_t      state_ff;
    logic          change_ff;
    logic          prox_out_ff, touch_out_ff, main_out_ff, main_en_ff, aux_out_ff;
    logic          ctrl_out_ff, ctrl_frz_ff, stream_ff, cal_dly_ff;
    tod_power_t    power_ff;
    tod_freeze_t   freeze_ff;
    logic [9:0]    gain_ff;
    logic [31:0]   prdata_ff;
    logic          pready_ff, pslverr_ff;
    logic [CW-1:0] run_count;
    logic          fire;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire setup_ph  = psel && !penable && !pready_ff;
    wire access_ok = psel && penable && pready_ff;
    wire wr_en     = access_ok && pwrite && !pslverr_ff;
    wire hit_thr   = (paddr == `TOD_OFF_THR);
    wire hit_mode  = (paddr == `TOD_OFF_MODE);
    wire hit_ana   = (paddr == `TOD_OFF_ANA);
    wire hit_ctrl  = (paddr == `TOD_OFF_CTRL);
    wire hit_dbc   = (paddr == `TOD_OFF_DBC);
    wire hit_stat  = (paddr == `TOD_OFF_STAT);
    wire hit_lvl   = (paddr == `TOD_OFF_LVL);
    wire mapped    = hit_thr | hit_mode | hit_ana | hit_ctrl | hit_dbc | hit_stat | hit_lvl;

    // options are frozen once latched; later writes are dropped without error
    wire opt_wr    = wr_en && !locked_ff;
    wire load_req  = wr_en && hit_ctrl && pwdata[`TOD_CTRL_LOAD] && !locked_ff;

    wire [31:0] rd_mux =
        hit_thr  ? {24'h0, thr_opt_ff}  :
        hit_mode ? {24'h0, mode_opt_ff} :
        hit_ana  ? {24'h0, ana_opt_ff}  :
        hit_ctrl ? {31'h0, locked_ff}   :
        hit_dbc  ? {{(24-CW){1'b0}}, exit_cnt_ff, {(8-CW){1'b0}}, entry_cnt_ff} :
        hit_stat ? {{(24-CW){1'b0}}, run_count, 5'h0, locked_ff, state_ff} :
        hit_lvl  ? {6'h0, release_lvl_ff, prox_lvl_ff, touch_lvl_ff} :
                   32'h0;

    // ----------------------------------------------------------------
    // apb slave: one wait-free access, answer set up at the setup edge
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else if (ce) begin
            pready_ff  <= setup_ph;
            pslverr_ff <= setup_ph && !mapped;
            prdata_ff  <= setup_ph ? rd_mux : 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // option bytes and debounce counts
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_opt_ff   <= `TOD_OPT_RST;
            mode_opt_ff  <= `TOD_OPT_RST;
            ana_opt_ff   <= `TOD_OPT_RST;
            entry_cnt_ff <= CW'(ENTRY_DEF);
            exit_cnt_ff  <= CW'(EXIT_DEF);
        end else if (ce && opt_wr) begin
            // reserved bits never store, so they read back as zero
            if (hit_thr) thr_opt_ff <= pwdata[7:0] & `TOD_THR_WMASK;
            if (hit_mode) mode_opt_ff <= pwdata[7:0] & `TOD_MODE_WMASK;
            if (hit_ana) ana_opt_ff <= pwdata[7:0] & `TOD_ANA_WMASK;
            if (hit_dbc && pwdata[CW-1:0] != '0) entry_cnt_ff <= pwdata[CW-1:0];
            if (hit_dbc && pwdata[`TOD_DBC_EXIT_LO +: CW] != '0) begin
                exit_cnt_ff <= pwdata[`TOD_DBC_EXIT_LO +: CW];
            end
        end
    end

    // ----------------------------------------------------------------
    // one-shot latch of the settings
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_ff  <= 1'b0;
            thr_lk_ff  <= `TOD_OPT_RST;
            mode_lk_ff <= `TOD_OPT_RST;
            ana_lk_ff  <= `TOD_OPT_RST;
        end else if (ce && load_req) begin
            locked_ff  <= 1'b1;
            thr_lk_ff  <= thr_opt_ff;
            mode_lk_ff <= mode_opt_ff;
            ana_lk_ff  <= ana_opt_ff;
        end
    end

    // ----------------------------------------------------------------
    // decoded settings, re-registered from the latched bytes
    // ----------------------------------------------------------------
    wire [9:0] touch_dec = touch_of(thr_lk_ff[`TOD_THR_TOUCH_LO +: 3]);
    wire [5:0] prox_dec  = prox_of(thr_lk_ff[`TOD_THR_PROX_LO +: 2]);
    wire       ratio_hi  = ana_lk_ff[`TOD_ANA_RATIO];
    wire       pol_high  = thr_lk_ff[`TOD_THR_POL];
    wire       dual_mode = mode_lk_ff[`TOD_MODE_DUAL];
    wire       stream_on = mode_lk_ff[`TOD_MODE_STREAM];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            touch_lvl_ff   <= `TOD_TOUCH_0;
            prox_lvl_ff    <= `TOD_PROX_0;
            release_lvl_ff <= 10'h01e;
            gain_ff        <= `TOD_GAIN_0;
            stream_ff      <= 1'b0;
            power_ff       <= TOD_PWR_NORMAL;
            freeze_ff      <= TOD_FRZ_INFINITE;
            cal_dly_ff     <= 1'b0;
            ctrl_out_ff    <= 1'b0;
            ctrl_frz_ff    <= 1'b0;
        end else if (ce) begin
            touch_lvl_ff   <= touch_dec;
            prox_lvl_ff    <= prox_dec;
            release_lvl_ff <= release_of(touch_dec, ratio_hi);
            gain_ff        <= gain_of(ana_lk_ff[`TOD_ANA_GAIN_LO +: 3]);
            stream_ff      <= stream_on;
            power_ff       <= tod_power_t'(mode_lk_ff[`TOD_MODE_PWR_LO +: 2]);
            freeze_ff      <= tod_freeze_t'(mode_lk_ff[`TOD_MODE_FRZ_LO +: 2]);
            cal_dly_ff     <= mode_lk_ff[`TOD_MODE_DYC];
            ctrl_out_ff    <= dual_mode;
            ctrl_frz_ff    <= thr_lk_ff[`TOD_THR_CTYPE];
        end
    end

    // ----------------------------------------------------------------
    // detection candidate from one sample
    // ----------------------------------------------------------------
    // deltas carry a sign bit so a negative difference never exceeds a level
    wire [SW:0] below = {1'b0, sample_reference} - {1'b0, sample_signal};
    wire [SW:0] above = {1'b0, sample_signal} - {1'b0, sample_reference};
    wire over_touch   = !below[SW] && (below[SW-1:0] > SW'(touch_lvl_ff));
    wire over_prox    = !below[SW] && (below[SW-1:0] > SW'(prox_lvl_ff));
    wire over_release = !above[SW] && (above[SW-1:0] > SW'(release_lvl_ff));

    tod_det_t cand;
    always_comb begin
        cand = state_ff;
        unique case (state_ff)
            TOD_IDLE: begin
                if (over_touch) cand = TOD_TOUCH;
                else if (over_prox) cand = TOD_PROX;
            end
            TOD_PROX: begin
                if (over_touch) cand = TOD_TOUCH;
                else if (!over_prox) cand = TOD_IDLE;
            end
            TOD_TOUCH: begin
                if (over_release) cand = TOD_IDLE;
            end
            default: cand = TOD_IDLE;
        endcase
    end

    // entering a detection uses one count, leaving it the other
    wire [CW-1:0] need = (cand == TOD_IDLE) ? exit_cnt_ff : entry_cnt_ff;

    // samples are ignored until the settings are latched
    wire take_sample = sample_vld && locked_ff;

    tod_debounce #(
        .CW         (CW)
    ) u_debounce (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .sample_vld (take_sample),
        .cur_state  (state_ff),
        .cand_state (cand),
        .required   (need),
        .run_count  (run_count),
        .fire       (fire)
    );

    // ----------------------------------------------------------------
    // detection state and pins
    // ----------------------------------------------------------------
    wire prox_det  = (state_ff != TOD_IDLE);
    wire touch_det = (state_ff == TOD_TOUCH);
    wire main_det  = (dual_mode || ana_lk_ff[`TOD_ANA_TYPE]) ? touch_det : prox_det;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff  <= TOD_IDLE;
            change_ff <= 1'b0;
        end else if (ce) begin
            change_ff <= take_sample && fire;
            if (take_sample && fire) state_ff <= cand;
        end
    end

    // outputs are held low during reset, before the polarity is latched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prox_out_ff  <= 1'b0;
            touch_out_ff <= 1'b0;
            main_out_ff  <= 1'b0;
            main_en_ff   <= 1'b0;
            aux_out_ff   <= 1'b0;
        end else if (ce) begin
            prox_out_ff  <= prox_det ~^ pol_high;
            touch_out_ff <= touch_det ~^ pol_high;
            main_out_ff  <= main_det ~^ pol_high;
            main_en_ff   <= !stream_on;
            aux_out_ff   <= dual_mode ? (prox_det ~^ pol_high) : 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata           = prdata_ff;
    assign pready           = pready_ff;
    assign pslverr          = pslverr_ff;
    assign det_state        = state_ff;
    assign det_change       = change_ff;
    assign prox_out         = prox_out_ff;
    assign touch_out        = touch_out_ff;
    assign main_out         = main_out_ff;
    assign main_out_en      = main_en_ff;
    assign aux_out          = aux_out_ff;
    assign ctrl_is_output   = ctrl_out_ff;
    assign ctrl_freeze_mode = ctrl_frz_ff;
    assign stream_en        = stream_ff;
    assign power_mode       = power_ff;
    assign freeze_sel       = freeze_ff;
    assign cal_delay_sel    = cal_dly_ff;
    assign gain_target      = gain_ff;

endmodule
